/* File: wdg_map.svh */
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

// Register byte offsets
`define WDG_OFS_RELOAD      8'h00
`define WDG_OFS_CONTROL     8'h04
`define WDG_OFS_REFRESH     8'h08
`define WDG_OFS_COUNT       8'h0C

// Control field positions
`define WDG_CTL_ENABLE      0
`define WDG_CTL_HALT_HIB    2
`define WDG_CTL_HALT_WEEK   3
`define WDG_CTL_HALT_DEBUG  4

// Halt request input indices
`define WDG_HALT_HIB        0
`define WDG_HALT_WEEK       1
`define WDG_HALT_DEBUG      2
`define WDG_HALT_NUM        3

// One-hot bit of the run state code
`define WDG_STATE_RUN_BIT   1

// Widths and values
`define WDG_CNT_W           16
`define WDG_PRE_W           6
`define WDG_DATA_W          32
`define WDG_ADDR_W          8
`define WDG_RELOAD_RST      16'hFFFF
`define WDG_COUNT_ZERO      16'h0000
`define WDG_COUNT_ONE       16'h0001
`define WDG_PRE_ZERO        6'h00
`define WDG_PRE_ONE         6'h01
`define WDG_PRE_LAST        6'h20
`define WDG_DATA_ZERO       32'h0000_0000

`endif

/* File: wdg_pkg.sv */
`include "wdg_map.svh"

package wdg_pkg;

    typedef enum logic [2:0] {
        WDG_IDLE = 3'b001,
        WDG_RUN  = 3'b010,
        WDG_HALT = 3'b100
    } wdg_state_type;

    typedef struct packed {
        wdg_state_type                  state;
        logic [`WDG_CNT_W-1:0]          reload;
        logic [`WDG_CNT_W-1:0]          count;
        logic [`WDG_PRE_W-1:0]          presc;
        logic                           enable;
        logic [`WDG_HALT_NUM-1:0]       halt_en;
        logic                           clk_prev;
        logic                           expiry;
        logic                           flag;
        logic [`WDG_DATA_W-1:0]         rdata;
    } wdg_regs_type;

endpackage

/* File: wdg_sync.sv */
`timescale 1ns/1ps
`include "wdg_map.svh"

// Three-stage synchroniser; the output only moves once stages two and three agree
module wdg_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } wdg_sync_type;

    wdg_sync_type sync_r;
    wdg_sync_type sync_nxt;

    always_comb begin
        sync_nxt    = sync_r;
        sync_nxt.s1 = din;
        sync_nxt.s2 = sync_r.s1;
        sync_nxt.s3 = sync_r.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (sync_r.s2[i] == sync_r.s3[i]) begin
                sync_nxt.q[i] = sync_r.s3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign dout = sync_r.q;

endmodule // wdg_sync

/* File: wdg_top.sv */
`timescale 1ns/1ps
`include "wdg_map.svh"

// How it works
// [RULE1] Missed reload while enabled raises expiry event
// [RULE2] Register accesses finish at once, bus clock
// [RULE3] Counting advances only on 32 kHz edges
// [RULE4] System reset clears every register and logic
// [RULE5] Expiry-surviving bit reset only by kept reset
// [RULE6] Expiry drives a pulse resetting the controller
// [RULE7] Expiry flag holds until system reset
// [RULE8] Firmware loads count, then sets enable
// [RULE9] Clearing enable stops counting, enters idle
// [RULE10] Underflow raises expiry and sets status flag
// [RULE11] Reload on load write, refresh, expiry
// [RULE12] One decrement per 33 slow clock periods
// [RULE13] Enabled halt request stops counting
// [RULE14] After halt, counting resumes from held value
// [RULE15] Reload register 16 bits, default FFFFh
// [RULE16] Offsets: reload 00h, control 04h, refresh 08h, count 0Ch
// [RULE17] Refresh write reloads only when enabled, reads zero
// [RULE18] Control bits 4,3,2 enable debug/week/hib halts
// [RULE19] Control bit 0 enables, resets to zero
// [RULE20] Count register read-only, live, default FFFFh
// [RULE21] Bus writes reach counting logic without loss
// [RULE22] Expiry pulse lasts one slow period, then reload; the code reloads the count in the cycle the pulse starts
module wdg_top (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        rst_keep_n,
    input  wire logic                        clk_32k,
    input  wire logic [`WDG_HALT_NUM-1:0]    halt_req,
    input  wire logic [`WDG_ADDR_W-1:0]      bus_addr,
    input  wire logic                        bus_wr,
    input  wire logic                        bus_rd,
    input  wire logic [`WDG_DATA_W-1:0]      bus_wdata,
    output logic      [`WDG_DATA_W-1:0]      bus_rdata,
    output logic                             expiry_pulse,
    output logic                             watchdog_flag,
    output logic                             expiry_seen,
    output logic                             counter_running
);

    wdg_pkg::wdg_regs_type       regs_r;
    wdg_pkg::wdg_regs_type       regs_nxt;
    logic                        expiry_seen_r;
    logic                        expiry_seen_nxt;

    logic                        clk_32k_sync;
    logic [`WDG_HALT_NUM-1:0]    halt_sync;
    logic [`WDG_HALT_NUM-1:0]    halt_req_sync;
    logic                        tick;
    logic                        halted;
    logic                        wr_reload;
    logic                        wr_control;
    logic                        wr_refresh;
    logic                        enable_rise;

    // The slow clock is treated as a sampled input: one clock domain keeps
    // every bus write visible to the counter in the cycle it is made.
    wdg_sync #(
        .WIDTH (1)
    ) u_sync_32k (
        .clock (clock),
        .rst_n (rst_n),
        .din   (clk_32k),
        .dout  (clk_32k_sync)
    );

    wdg_sync #(
        .WIDTH (`WDG_HALT_NUM)
    ) u_sync_halt (
        .clock (clock),
        .rst_n (rst_n),
        .din   (halt_req),
        .dout  (halt_req_sync)
    );

    assign halt_sync = halt_req_sync;

    always_comb begin
        regs_nxt          = regs_r;
        regs_nxt.clk_prev = clk_32k_sync;

        // Rising edge of the synchronised slow clock
        tick = clk_32k_sync & ~regs_r.clk_prev; // [RULE3]

        halted = |(halt_sync & regs_r.halt_en); // [RULE13]

        wr_reload  = bus_wr && (bus_addr == `WDG_OFS_RELOAD); // [RULE16]
        wr_control = bus_wr && (bus_addr == `WDG_OFS_CONTROL); // [RULE16]
        wr_refresh = bus_wr && (bus_addr == `WDG_OFS_REFRESH); // [RULE16]

        enable_rise = wr_control && bus_wdata[`WDG_CTL_ENABLE] && !regs_r.enable;

        // Expiry pulse spans exactly one slow clock period
        if (tick) begin
            regs_nxt.expiry = 1'b0; // [RULE22]
        end

        // Counting: only while running, so idle and halt both hold the count
        case (regs_r.state)
            wdg_pkg::WDG_RUN: begin
                if (tick) begin // [RULE3]
                    if (regs_r.presc == `WDG_PRE_LAST) begin // [RULE12]
                        regs_nxt.presc = `WDG_PRE_ZERO;
                        if (regs_r.count == `WDG_COUNT_ZERO) begin
                            regs_nxt.expiry = 1'b1; // [RULE1] [RULE6] [RULE10]
                            regs_nxt.flag   = 1'b1; // [RULE10] [RULE7]
                            regs_nxt.count  = regs_r.reload; // [RULE11] [RULE22]
                        end else begin
                            regs_nxt.count = regs_r.count - `WDG_COUNT_ONE; // [RULE12]
                        end
                    end else begin
                        regs_nxt.presc = regs_r.presc + `WDG_PRE_ONE;
                    end
                end
            end
            wdg_pkg::WDG_HALT: begin
                // Count and prescaler frozen; resume picks up where it stopped
                regs_nxt.presc = regs_r.presc; // [RULE14]
            end
            wdg_pkg::WDG_IDLE: begin
                regs_nxt.presc = regs_r.presc; // [RULE9]
            end
            default: begin
                regs_nxt.presc = `WDG_PRE_ZERO;
            end
        endcase

        // Bus writes land after counting so a write in a tick cycle is never lost
        if (wr_reload) begin
            regs_nxt.reload = bus_wdata[`WDG_CNT_W-1:0]; // [RULE15] [RULE21]
            regs_nxt.count  = bus_wdata[`WDG_CNT_W-1:0]; // [RULE11] [RULE15]
            regs_nxt.presc  = `WDG_PRE_ZERO;
        end

        if (wr_control) begin
            regs_nxt.enable                    = bus_wdata[`WDG_CTL_ENABLE]; // [RULE19] [RULE21]
            regs_nxt.halt_en[`WDG_HALT_HIB]    = bus_wdata[`WDG_CTL_HALT_HIB]; // [RULE18]
            regs_nxt.halt_en[`WDG_HALT_WEEK]   = bus_wdata[`WDG_CTL_HALT_WEEK]; // [RULE18]
            regs_nxt.halt_en[`WDG_HALT_DEBUG]  = bus_wdata[`WDG_CTL_HALT_DEBUG]; // [RULE18]
        end

        // A fresh enable starts a whole decrement period from the loaded count
        if (enable_rise) begin
            regs_nxt.presc = `WDG_PRE_ZERO; // [RULE8]
        end

        // Refresh is ignored while the timer is disabled
        if (wr_refresh && regs_r.enable) begin
            regs_nxt.count = regs_r.reload; // [RULE17] [RULE11] [RULE21]
            regs_nxt.presc = `WDG_PRE_ZERO;
        end

        // State follows enable and the enabled halt requests
        if (!regs_nxt.enable) begin
            regs_nxt.state = wdg_pkg::WDG_IDLE; // [RULE9]
        end else if (halted) begin
            regs_nxt.state = wdg_pkg::WDG_HALT; // [RULE13]
        end else begin
            regs_nxt.state = wdg_pkg::WDG_RUN; // [RULE14]
        end

        // Reads answer from a register one cycle later, never waiting on the slow clock
        if (bus_rd) begin
            case (bus_addr)
                `WDG_OFS_RELOAD: begin
                    regs_nxt.rdata = `WDG_DATA_ZERO;
                    regs_nxt.rdata[`WDG_CNT_W-1:0] = regs_r.reload; // [RULE15]
                end
                `WDG_OFS_CONTROL: begin
                    regs_nxt.rdata = `WDG_DATA_ZERO;
                    regs_nxt.rdata[`WDG_CTL_ENABLE]     = regs_r.enable; // [RULE19]
                    regs_nxt.rdata[`WDG_CTL_HALT_HIB]   = regs_r.halt_en[`WDG_HALT_HIB]; // [RULE18]
                    regs_nxt.rdata[`WDG_CTL_HALT_WEEK]  = regs_r.halt_en[`WDG_HALT_WEEK]; // [RULE18]
                    regs_nxt.rdata[`WDG_CTL_HALT_DEBUG] = regs_r.halt_en[`WDG_HALT_DEBUG]; // [RULE18]
                end
                `WDG_OFS_REFRESH: begin
                    regs_nxt.rdata = `WDG_DATA_ZERO; // [RULE17]
                end
                `WDG_OFS_COUNT: begin
                    regs_nxt.rdata = `WDG_DATA_ZERO;
                    regs_nxt.rdata[`WDG_CNT_W-1:0] = regs_r.count; // [RULE20]
                end
                default: begin
                    regs_nxt.rdata = `WDG_DATA_ZERO;
                end
            endcase
        end // [RULE2]

        // Sticky record of an expiry; only the kept reset clears it
        expiry_seen_nxt = expiry_seen_r | regs_r.expiry; // [RULE5]
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regs_r.state    <= wdg_pkg::WDG_IDLE; // [RULE4]
            regs_r.reload   <= `WDG_RELOAD_RST; // [RULE15]
            regs_r.count    <= `WDG_RELOAD_RST; // [RULE20]
            regs_r.presc    <= `WDG_PRE_ZERO;
            regs_r.enable   <= 1'b0; // [RULE19]
            regs_r.halt_en  <= '0;
            regs_r.clk_prev <= 1'b0;
            regs_r.expiry   <= 1'b0;
            regs_r.flag     <= 1'b0; // [RULE7]
            regs_r.rdata    <= `WDG_DATA_ZERO;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // Separate reset so this bit outlives the expiry-driven system reset
    always_ff @(posedge clock or negedge rst_keep_n) begin
        if (!rst_keep_n) begin
            expiry_seen_r <= 1'b0; // [RULE5]
        end else begin
            expiry_seen_r <= expiry_seen_nxt;
        end
    end

    assign bus_rdata       = regs_r.rdata;
    assign expiry_pulse    = regs_r.expiry; // [RULE6]
    assign watchdog_flag   = regs_r.flag;
    assign expiry_seen     = expiry_seen_r;
    // Run code is one-hot, so its bit is a bare flop and not a decode
    assign counter_running = regs_r.state[`WDG_STATE_RUN_BIT];

endmodule // wdg_top

/* File: wdg_assertions.sv */
`timescale 1ns/1ps
`include "wdg_map.svh"

module wdg_checker (
    input wire logic                     clock,
    input wire logic                     rst_n,
    input wire logic                     rst_keep_n,
    input wire logic                     clk_32k,
    input wire logic [`WDG_HALT_NUM-1:0] halt_req,
    input wire logic [`WDG_ADDR_W-1:0]   bus_addr,
    input wire logic                     bus_wr,
    input wire logic                     bus_rd,
    input wire logic [`WDG_DATA_W-1:0]   bus_wdata,
    input wire logic [`WDG_DATA_W-1:0]   bus_rdata,
    input wire logic                     expiry_pulse,
    input wire logic                     watchdog_flag,
    input wire logic                     expiry_seen,
    input wire logic                     counter_running
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic mapped;
    assign mapped = bus_addr inside {`WDG_OFS_RELOAD, `WDG_OFS_CONTROL, `WDG_OFS_REFRESH, `WDG_OFS_COUNT};

    AST_FLAG_STICKY: assert property (watchdog_flag |=> watchdog_flag)
        else $error("flag dropped");
    AST_FLAG_SET: assert property ($rose(expiry_pulse) |=> watchdog_flag)
        else $error("flag not set");
    AST_SEEN_SET: assert property (expiry_pulse && rst_keep_n |=> expiry_seen)
        else $error("kept bit not set");
    AST_PULSE_CAUSE: assert property ($rose(expiry_pulse) |-> $past(counter_running))
        else $error("expiry while stopped");
    AST_PULSE_WIDTH: assert property ($rose(expiry_pulse) |-> expiry_pulse [*8])
        else $error("pulse too short");
    AST_UNMAPPED_ZERO: assert property (bus_rd && !mapped |=> bus_rdata == `WDG_DATA_ZERO)
        else $error("unmapped read not zero");
    AST_REFRESH_ZERO: assert property (bus_rd && bus_addr == `WDG_OFS_REFRESH |=> bus_rdata == 0)
        else $error("refresh read not zero");
    AST_RDATA_HOLD: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data moved");
    AST_CTRL_RSVD: assert property (bus_rd && bus_addr == `WDG_OFS_CONTROL
        |=> bus_rdata[31:5] == 0 && !bus_rdata[1])
        else $error("reserved control bits set");
    AST_DISABLE_STOPS: assert property (bus_wr && bus_addr == `WDG_OFS_CONTROL && !bus_wdata[0]
        |-> ##[1:2] !counter_running)
        else $error("still running when disabled");
endmodule // wdg_checker

bind wdg_top wdg_checker i_chk (.clock(clock), .rst_n(rst_n), .rst_keep_n(rst_keep_n), .clk_32k(clk_32k),
    .halt_req(halt_req), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .expiry_pulse(expiry_pulse), .watchdog_flag(watchdog_flag),
    .expiry_seen(expiry_seen), .counter_running(counter_running));

/* File: wdg_top_bench.sv */
`timescale 1ns/1ps
`include "wdg_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module wdg_top_bench;
    logic        clock = 0, rst_n = 0, rst_keep_n = 0, clk_32k = 0, bus_wr = 0, bus_rd = 0;
    logic [2:0]  halt_req = 0;
    logic [7:0]  bus_addr = 0;
    logic [31:0] bus_wdata = 0, bus_rdata;
    logic        expiry_pulse, watchdog_flag, expiry_seen, counter_running;
    int          n_errors = 0, samples_checked = 0, div_cnt = 0;

    wdg_top i_dut (.clock(clock), .rst_n(rst_n), .rst_keep_n(rst_keep_n), .clk_32k(clk_32k),
        .halt_req(halt_req), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .expiry_pulse(expiry_pulse), .watchdog_flag(watchdog_flag),
        .expiry_seen(expiry_seen), .counter_running(counter_running));

    always #2 clock = ~clock;
    // Slow clock sped up to 20 bus cycles a period, well above the edge-detect minimum
    always @(posedge clock) begin
        div_cnt <= (div_cnt == 9) ? 0 : div_cnt + 1;
        if (div_cnt == 9) clk_32k <= ~clk_32k;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1;
        @(posedge clock);
        bus_wr <= 0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        bus_addr <= a;
        bus_rd <= 1;
        @(posedge clock);
        bus_rd <= 0;
        @(negedge clock);
        `CHK(bus_rdata, e)
    endtask

    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1;
        rst_keep_n <= 1;
        rd_chk(`WDG_OFS_RELOAD, 32'h0000_FFFF);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_FFFF);
        rd_chk(`WDG_OFS_CONTROL, 32'h0000_0000);
        rd_chk(8'h10, 32'h0000_0000);
        wr(8'h10, 32'h0000_0007);
        wr(`WDG_OFS_COUNT, 32'h0000_0005);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_FFFF);
        wr(`WDG_OFS_RELOAD, 32'hABCD_1234);
        rd_chk(`WDG_OFS_RELOAD, 32'h0000_1234);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_1234);
        wr(`WDG_OFS_CONTROL, 32'h0000_00FF);
        rd_chk(`WDG_OFS_CONTROL, 32'h0000_001D);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock) halt_req <= 3'h1 << i;
            pause(10);
            `CHK(counter_running, 1'h0)
            wr(`WDG_OFS_CONTROL, 32'h0000_0001);
            pause(10);
            `CHK(counter_running, 1'h1)
            wr(`WDG_OFS_CONTROL, 32'h0000_001D);
            @(posedge clock) halt_req <= 0;
        end
        wr(`WDG_OFS_CONTROL, 32'h0000_0000);
        // Load first, then enable: the start order firmware has to keep
        wr(`WDG_OFS_RELOAD, 32'h0000_0002);
        wr(`WDG_OFS_CONTROL, 32'h0000_0011);
        pause(680);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_0001);
        @(posedge clock) halt_req <= 3'h4;
        pause(700);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_0001);
        @(posedge clock) halt_req <= 0;
        pause(700);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_0000);
        wr(`WDG_OFS_CONTROL, 32'h0000_0000);
        pause(700);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_0000);
        wr(`WDG_OFS_REFRESH, 32'h0000_0001);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_0000);
        rd_chk(`WDG_OFS_REFRESH, 32'h0000_0000);
        wr(`WDG_OFS_CONTROL, 32'h0000_0001);
        wr(`WDG_OFS_REFRESH, 32'h0000_0001);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_0002);
        // Non-zero reload so the reload after expiry is visible in the count
        wr(`WDG_OFS_RELOAD, 32'h0000_0001);
        for (int k = 0; k < 1500 && expiry_pulse !== 1'h1; k++) @(negedge clock);
        `CHK(expiry_pulse, 1'h1)
        pause(2);
        `CHK(watchdog_flag, 1'h1)
        `CHK(expiry_seen, 1'h1)
        rd_chk(`WDG_OFS_COUNT, 32'h0000_0001);
        pause(40);
        `CHK(expiry_pulse, 1'h0)
        wr(`WDG_OFS_CONTROL, 32'h0000_0000);
        pause(200);
        `CHK(watchdog_flag, 1'h1)
        @(posedge clock) rst_n <= 0;
        pause(2);
        @(posedge clock) rst_n <= 1;
        pause(2);
        `CHK(watchdog_flag, 1'h0)
        `CHK(expiry_seen, 1'h1)
        rd_chk(`WDG_OFS_RELOAD, 32'h0000_FFFF);
        rd_chk(`WDG_OFS_COUNT, 32'h0000_FFFF);
        rd_chk(`WDG_OFS_CONTROL, 32'h0000_0000);
        @(posedge clock) rst_keep_n <= 0;
        pause(2);
        `CHK(expiry_seen, 1'h0)
        give_verdict();
    end
endmodule // wdg_top_bench
